/* testbench/scis_link_sva.sv */
/*
   Assertions on the link and card pins of the supervisor.
   Assumes a step count of 20 cycles and an instance beside the link.
*/
`timescale 1ns/100ps
module scis_link_sva (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Link
   input wire logic activation_request_n,
   input wire logic irq_n,
   input wire logic supply_class_select,
   // Card side
   input wire logic CARD_DETECT_INPUT_N_I,
   input wire logic CARD_DETECT_INPUT_I,
   input wire logic OVERCURRENT_FAULT_I,
   input wire logic OVERTEMP_FAULT_I,
   input wire logic UNDERVOLTAGE_FAULT_I,
   input wire logic [2:0] CARD_LINE_OE_N_O,
   input wire logic CARD_CLOCK_OUT_O,
   input wire logic CARD_RESET_OUT_O,
   input wire logic CARD_SUPPLY_ON_O,
   input wire logic CARD_SUPPLY_HIGH_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   logic absent;
   assign absent = CARD_DETECT_INPUT_N_I && !CARD_DETECT_INPUT_I;
   a_request_edge_starts: assert property ($rose(CARD_SUPPLY_ON_O) |->
      !$past(activation_request_n, 2) && $past(activation_request_n, 3))
      else $error("supply rose without request edge");
   a_lines_after_supply: assert property ($rose(CARD_LINE_OE_N_O[0]) |->
      CARD_SUPPLY_ON_O && $past(CARD_SUPPLY_ON_O, 10))
      else $error("line released too early");
   a_reset_released_last: assert property ($rose(CARD_RESET_OUT_O) |->
      $past(CARD_SUPPLY_ON_O, 50))
      else $error("card reset rose too early");
   a_supply_off_last: assert property ($fell(CARD_SUPPLY_ON_O) |->
      !CARD_RESET_OUT_O && !CARD_CLOCK_OUT_O && CARD_LINE_OE_N_O == 3'h0)
      else $error("supply dropped before other pins");
   a_request_high_stops: assert property ($rose(activation_request_n) |->
      ##[1:100] !CARD_SUPPLY_ON_O)
      else $error("request release did not deactivate");
   a_fault_deactivates: assert property (
      $rose(OVERCURRENT_FAULT_I || OVERTEMP_FAULT_I || absent) |-> ##[1:100] !CARD_SUPPLY_ON_O)
      else $error("fault did not deactivate");
   a_low_supply_off: assert property (UNDERVOLTAGE_FAULT_I[*3] |->
      !CARD_SUPPLY_ON_O && !CARD_CLOCK_OUT_O && !CARD_RESET_OUT_O && CARD_LINE_OE_N_O == 3'h0)
      else $error("card pins live in undervoltage");
   a_irq_needs_cause: assert property (
      (absent && !OVERCURRENT_FAULT_I)[*4] |-> irq_n)
      else $error("interrupt without cause");
   a_irq_on_overload: assert property (OVERCURRENT_FAULT_I[*4] |-> !irq_n)
      else $error("no interrupt on overload");
   a_class_follows: assert property (
      (CARD_SUPPLY_ON_O && $stable(supply_class_select))[*3] |->
      CARD_SUPPLY_HIGH_O == supply_class_select)
      else $error("supply class mismatch");
   c_activation: cover property ($rose(CARD_SUPPLY_ON_O));
   c_deactivation: cover property ($fell(CARD_SUPPLY_ON_O));
   c_interrupt: cover property ($fell(irq_n));
endmodule

/* testbench/test_smart_card_interface_supervisor.sv */
/*
   Bench joining the supervisor and host controller over the link.
   Assumes short debounce and step counts, set at the instances.
*/
`timescale 1ns/100ps
module test_smart_card_interface_supervisor;
   import scis_pkg::*;
   localparam int DB = 50;
   logic clk, rst, wr, rd, irq, det_n, det, ovc, ovt, uvf, cclk, crst, son, shi;
   logic [3:0] addr;
   logic [7:0] wd, rdata, v;
   logic [2:0] ldl, ldo, card_low, card_line, oe_n, cdo;
   int mismatches, checks_done;
   scis_link_if link();
   scis_supervisor #(.DEBOUNCE_COUNT(DB), .STEP_COUNT(20)) u_scis_supervisor (
      .CLK_I(clk), .RESET_I(rst), .LINK(link), .CARD_DETECT_INPUT_N_I(det_n),
      .CARD_DETECT_INPUT_I(det), .OVERCURRENT_FAULT_I(ovc), .OVERTEMP_FAULT_I(ovt),
      .UNDERVOLTAGE_FAULT_I(uvf), .CARD_LINE_I(card_line), .CARD_LINE_O(cdo),
      .CARD_LINE_OE_N_O(oe_n), .CARD_CLOCK_OUT_O(cclk), .CARD_RESET_OUT_O(crst),
      .CARD_SUPPLY_ON_O(son), .CARD_SUPPLY_HIGH_O(shi));
   scis_host_ctrl u_scis_host_ctrl (
      .CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .IRQ_O(irq), .LINE_DATA_I(~ldl), .LINE_DRIVE_LOW_I(ldl),
      .LINE_DATA_O(ldo), .LINK(link));
   scis_link_sva u_scis_link_sva (
      .CLK_I(clk), .RESET_I(rst), .activation_request_n(link.activation_request_n),
      .irq_n(link.irq_n), .supply_class_select(link.supply_class_select),
      .CARD_DETECT_INPUT_N_I(det_n), .CARD_DETECT_INPUT_I(det), .OVERCURRENT_FAULT_I(ovc),
      .OVERTEMP_FAULT_I(ovt), .UNDERVOLTAGE_FAULT_I(uvf), .CARD_LINE_OE_N_O(oe_n),
      .CARD_CLOCK_OUT_O(cclk), .CARD_RESET_OUT_O(crst), .CARD_SUPPLY_ON_O(son),
      .CARD_SUPPLY_HIGH_O(shi));
   // The card side lines have a pull-up, so they fall only when someone drives them.
   assign card_line = oe_n & ~card_low;
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task expr(input string s, input logic [3:0] a, input logic [7:0] e);
      rreg(a, v);
      chk(s, e, v);
   endtask
   task act(input logic [7:0] d);
      wreg(REG_CTRL, 8'h00);
      wreg(REG_CTRL, d);
      cyc(100);
   endtask
   // Counts host clock rises within one full card clock period.
   task measure(output logic [7:0] n);
      logic pc, ph;
      int k;
      cyc(40);
      n = 8'h00;
      k = 0;
      pc = cclk;
      ph = link.host_clock_in;
      for (int t = 0; t < 400 && k < 2; t++)
      begin
         cyc(1);
         if (k == 1 && !ph && link.host_clock_in)
            n++;
         if (!pc && cclk)
            k++;
         pc = cclk;
         ph = link.host_clock_in;
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #50000;
      mismatches++;
      final_report;
   end
   initial
   begin
      {rst, wr, rd, det, ovc, ovt, uvf, addr, wd, ldl, card_low} = {7'h40, 18'h0};
      det_n = 1'b1;
      cyc(10);
      @(posedge clk) rst <= 1'b0;
      expr("ctrl", REG_CTRL, CTRL_RESET_VALUE);
      expr("mask", REG_MASK, MASK_RESET_VALUE);
      expr("unmapped", 4'hF, 8'h00);
      chk("pins", 8'h00, {oe_n, son, cclk, crst, 2'h0});
      chk("card data", 8'h00, {5'h0, cdo});
      $display("test reset done");
      @(posedge clk) det_n <= 1'b0;
      cyc(DB / 2);
      expr("debounce", REG_STATUS, 8'h02);
      cyc(DB);
      expr("present", REG_STATUS, 8'h03);
      chk("irq masked", 8'h00, {7'h00, irq});
      wreg(REG_MASK, 8'h01);
      cyc(2);
      chk("irq", 8'h01, {7'h00, irq});
      wreg(REG_EVENT, 8'h03);
      cyc(2);
      chk("irq cleared", 8'h00, {7'h00, irq});
      $display("test presence done");
      act(8'h27);
      chk("active", 8'h1F, {3'h0, son, shi, oe_n});
      chk("card reset", 8'h01, {7'h00, crst});
      for (int i = 0; i < 4; i++)
      begin
         wreg(REG_CTRL, 8'h27 | 8'(i << 3));
         measure(v);
         chk("ratio", 8'h01 << i, v);
      end
      wreg(REG_CTRL, 8'h25);
      cyc(6);
      chk("card reset", 8'h00, {7'h00, crst});
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk) ldl <= 3'h1 << i;
         cyc(6);
         chk("to card", 8'h07 ^ (8'h01 << i), {5'h0, card_line});
         @(posedge clk) {ldl, card_low} <= {3'h0, 3'h1 << i};
         cyc(6);
         chk("to host", 8'h07 ^ (8'h01 << i), {5'h0, ldo});
         @(posedge clk) card_low <= 3'h0;
         cyc(6);
         chk("idle", 8'h3F, {2'h0, ldo, card_line});
      end
      wreg(REG_CTRL, 8'h24);
      cyc(100);
      chk("off", 8'h00, {3'h0, son, crst, oe_n});
      expr("event", REG_EVENT, 8'h02);
      $display("test activation done");
      for (int i = 0; i < 4; i++)
      begin
         act(8'h23);
         chk("class low", 8'h17, {3'h0, son, shi, oe_n});
         @(posedge clk) {uvf, ovt, ovc, det_n} <= 4'h1 << i;
         cyc(100);
         chk("fault off", 8'h00, {2'h0, son, cclk, crst, oe_n});
         @(posedge clk) {uvf, ovt, ovc, det_n} <= 4'h0;
         cyc(DB + 10);
      end
      $display("test faults done");
      wreg(REG_CTRL, 8'h00);
      @(posedge clk) {ovc, det_n} <= 2'h3;
      cyc(6);
      expr("overload", REG_STATUS, 8'h03);
      @(posedge clk) ovc <= 1'b0;
      cyc(6);
      expr("absent", REG_STATUS, 8'h02);
      act(8'h23);
      chk("refused", 8'h00, {7'h00, son});
      wreg(REG_CTRL, 8'h00);
      @(posedge clk) det <= 1'b1;
      cyc(DB + 10);
      expr("high detect", REG_STATUS, 8'h03);
      $display("test detect done");
      final_report;
   end
endmodule

/* verilog/scis_host_ctrl.sv */
/*
   Host controller end: registers reached over a plain strobe port drive the link pins.
   Assumes one CLK_I shared with the supervisor; read data follow a read strobe by one cycle.
*/
`timescale 1ns/100ps
module scis_host_ctrl (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Register port
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   output logic IRQ_O,
   // Host side serial lines
   input wire logic [2:0] LINE_DATA_I,
   input wire logic [2:0] LINE_DRIVE_LOW_I,
   output logic [2:0] LINE_DATA_O,
   // Link
   scis_link_if.host LINK
);
   import scis_pkg::*;

   logic [7:0] ctrl;
   logic [EVENT_BITS-1:0] events;
   logic [EVENT_BITS-1:0] mask;
   logic irq_prev;
   logic act_prev;
   logic [EVENT_BITS-1:0] hit;

   assign hit = {LINK.activation_request_n != act_prev, LINK.irq_n != irq_prev};

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         ctrl <= CTRL_RESET_VALUE;
      else if (WR_I && ADDR_I == REG_CTRL)
         ctrl <= WDATA_I;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         mask <= MASK_RESET_VALUE[EVENT_BITS-1:0];
      else if (WR_I && ADDR_I == REG_MASK)
         mask <= WDATA_I[EVENT_BITS-1:0];
   end

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         events <= '0;
         irq_prev <= 1'b1;
         act_prev <= 1'b1;
      end
      else
      begin
         irq_prev <= LINK.irq_n;
         act_prev <= LINK.activation_request_n;
         if (WR_I && ADDR_I == REG_EVENT)
            events <= (events & ~WDATA_I[EVENT_BITS-1:0]) | hit;
         else
            events <= events | hit;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         IRQ_O <= 1'b0;
      else
         IRQ_O <= |(events & mask);
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || !RD_I)
         RDATA_O <= '0;
      else
      begin
         case (ADDR_I)
            REG_CTRL: RDATA_O <= ctrl;
            REG_STATUS: RDATA_O <= {6'h00, LINK.activation_request_n, ~LINK.irq_n};
            REG_EVENT: RDATA_O <= 8'(events);
            REG_MASK: RDATA_O <= 8'(mask);
            default: RDATA_O <= '0;
         endcase
      end
   end

   // The host clock runs well below the maximum, so every ratio is legal.
   logic [HOST_CLK_DIV_BITS-1:0] clk_div;
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         clk_div <= '0;
         LINK.host_clock_in <= 1'b0;
         LINK.activation_request_n <= 1'b1;
         LINK.host_reset_in <= 1'b0;
         LINK.supply_class_select <= 1'b0;
         LINK.clock_ratio_select_a <= 1'b0;
         LINK.clock_ratio_select_b <= 1'b0;
         LINK.host_line_from_host <= '0;
         LINK.host_line_oe_n_host <= 3'h7;
         LINE_DATA_O <= 3'h7;
      end
      else
      begin
         clk_div <= clk_div + HOST_CLK_DIV_BITS'(1'b1);
         LINK.host_clock_in <= ctrl[CTRL_CLKGATE] & clk_div[HOST_CLK_DIV_BITS-1];
         LINK.activation_request_n <= ~ctrl[CTRL_ACTIVATE];
         LINK.host_reset_in <= ctrl[CTRL_RESET];
         LINK.supply_class_select <= ctrl[CTRL_CLASS];
         LINK.clock_ratio_select_a <= ctrl[CTRL_DIV_LO];
         LINK.clock_ratio_select_b <= ctrl[CTRL_DIV_LO+1];
         LINK.host_line_from_host <= '0;
         LINK.host_line_oe_n_host <= ~LINE_DRIVE_LOW_I;
         LINE_DATA_O <= LINE_DATA_I & LINK.host_line_oe_n_dev;
      end
   end
endmodule

/* verilog/scis_link_if.sv */
/*
   Pin-level link between the host controller and the card supervisor.
   Assumes the host controller resolves the host-side two-way lines from the enables.
*/
`timescale 1ns/100ps
interface scis_link_if;
   logic clock_ratio_select_a;
   logic clock_ratio_select_b;
   logic supply_class_select;
   logic activation_request_n;
   logic host_reset_in;
   logic host_clock_in;
   logic irq_n;
   logic [2:0] host_line_from_dev;
   logic [2:0] host_line_oe_n_dev;
   logic [2:0] host_line_from_host;
   logic [2:0] host_line_oe_n_host;
   modport device (
      input clock_ratio_select_a, clock_ratio_select_b, supply_class_select,
      input activation_request_n, host_reset_in, host_clock_in,
      input host_line_from_host, host_line_oe_n_host,
      output irq_n, host_line_from_dev, host_line_oe_n_dev
   );
   modport host (
      output clock_ratio_select_a, clock_ratio_select_b, supply_class_select,
      output activation_request_n, host_reset_in, host_clock_in,
      output host_line_from_host, host_line_oe_n_host,
      input irq_n, host_line_from_dev, host_line_oe_n_dev
   );
endinterface

/* verilog/scis_pkg.sv */
/*
   Shared constants for the card interface supervisor and its host-side controller.
   Assumes a single 200 MHz clock shared by both ends.
*/
package scis_pkg;
   localparam int CLK_MHZ = 200;
   localparam int DEBOUNCE_MS = 8;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int STEP_NS = 100;
   localparam int STEP_CYCLES = (STEP_NS * CLK_MHZ + 999) / 1000;
   // The host input clock is CLK_I divided by two to this power, slow enough undivided too.
   localparam int HOST_CLK_DIV_BITS = 4;
   localparam logic [1:0] DIV_BY_1 = 2'h0;
   localparam logic [1:0] DIV_BY_2 = 2'h1;
   localparam logic [1:0] DIV_BY_4 = 2'h2;
   localparam logic [1:0] DIV_BY_8 = 2'h3;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_EVENT = 4'h2;
   localparam logic [3:0] REG_MASK = 4'h3;
   localparam int CTRL_ACTIVATE = 0;
   localparam int CTRL_RESET = 1;
   localparam int CTRL_CLASS = 2;
   localparam int CTRL_DIV_LO = 3;
   localparam int CTRL_CLKGATE = 5;
   localparam int EV_IRQ = 0;
   localparam int EV_ACTIVE_CHG = 1;
   localparam int EVENT_BITS = 2;
   localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
   localparam logic [7:0] MASK_RESET_VALUE = 8'h00;
endpackage

/* verilog/scis_supervisor.sv */
/*
   Card side supervisor: presence debounce, activation and deactivation sequencing,
   card clock divider, reset and line pass-through, and interrupt.
   Assumes host pins are synchronous to CLK_I and the host keeps its input clock in range.
*/
`timescale 1ns/100ps
// Functional notes
// - Divide by 1, 2, 4 or 8 per selects.
// - Card clock comes from host clock via divider.
// - Host keeps input clock within maximum.
// - Maximum clock only with ratio two or more.
// - Present on low active-low or high active-high detect.
// - Accept presence after detect stable debounce time.
// - Supply class select picks high or low supply.
// - Activate on request falling edge with card present.
// - Request low keeps active; high deactivates.
// - Card reset follows host reset input.
// - Three buffered two-way paths host to card.
// - Card lines idle high through pull-up.
// - Interrupt low while card present.
// - Interrupt low on card supply overload.
// - Card outputs disabled during undervoltage.
// - Faults or removal start automatic deactivation.
module scis_supervisor #(
   parameter int DEBOUNCE_COUNT = scis_pkg::DEBOUNCE_CYCLES,
   parameter int STEP_COUNT = scis_pkg::STEP_CYCLES
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Host link
   scis_link_if.device LINK,
   // Card detect and fault sense
   input wire logic CARD_DETECT_INPUT_N_I,
   input wire logic CARD_DETECT_INPUT_I,
   input wire logic OVERCURRENT_FAULT_I,
   input wire logic OVERTEMP_FAULT_I,
   input wire logic UNDERVOLTAGE_FAULT_I,
   // Card side lines
   input wire logic [2:0] CARD_LINE_I,
   output logic [2:0] CARD_LINE_O,
   output logic [2:0] CARD_LINE_OE_N_O,
   output logic CARD_CLOCK_OUT_O,
   output logic CARD_RESET_OUT_O,
   output logic CARD_SUPPLY_ON_O,
   output logic CARD_SUPPLY_HIGH_O
);
   import scis_pkg::*;

   typedef enum {ST_OFF, ST_PWR, ST_LINES, ST_CLK, ST_ACTIVE, ST_D_RST, ST_D_CLK,
      ST_D_LINES, ST_D_PWR} scis_seq_type;

   scis_seq_type state;
   logic [31:0] deb_cnt;
   logic present;
   logic [31:0] step_cnt;
   logic step_done;
   logic req_prev;
   logic [2:0] div_cnt;
   logic clk_run;
   logic lines_on;
   logic rst_follow;
   logic fault;
   logic [1:0] div_sel;
   logic raw_present;

   assign raw_present = ~CARD_DETECT_INPUT_N_I | CARD_DETECT_INPUT_I;
   assign fault = OVERCURRENT_FAULT_I | OVERTEMP_FAULT_I | UNDERVOLTAGE_FAULT_I | ~present;
   assign step_done = (step_cnt >= 32'(STEP_COUNT - 1));
   assign div_sel = {LINK.clock_ratio_select_b, LINK.clock_ratio_select_a};

   // Presence is only accepted after a full quiet interval; removal drops it at once.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || !raw_present)
      begin
         deb_cnt <= '0;
         present <= 1'b0;
      end
      else if (deb_cnt >= 32'(DEBOUNCE_COUNT - 1))
         present <= 1'b1;
      else
         deb_cnt <= deb_cnt + 32'h1;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         req_prev <= 1'b1;
      else
         req_prev <= LINK.activation_request_n;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || state == ST_OFF || state == ST_ACTIVE || step_done)
         step_cnt <= '0;
      else
         step_cnt <= step_cnt + 32'h1;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         state <= ST_OFF;
      else
      begin
         case (state)
            ST_OFF:
               if (req_prev && !LINK.activation_request_n && present && !fault)
                  state <= ST_PWR;
            ST_PWR:
               if (fault || LINK.activation_request_n)
                  state <= ST_D_RST;
               else if (step_done)
                  state <= ST_LINES;
            ST_LINES:
               if (fault || LINK.activation_request_n)
                  state <= ST_D_RST;
               else if (step_done)
                  state <= ST_CLK;
            ST_CLK:
               if (fault || LINK.activation_request_n)
                  state <= ST_D_RST;
               else if (step_done)
                  state <= ST_ACTIVE;
            ST_ACTIVE:
               if (fault || LINK.activation_request_n)
                  state <= ST_D_RST;
            ST_D_RST:
               if (step_done)
                  state <= ST_D_CLK;
            ST_D_CLK:
               if (step_done)
                  state <= ST_D_LINES;
            ST_D_LINES:
               if (step_done)
                  state <= ST_D_PWR;
            ST_D_PWR:
               if (step_done)
                  state <= ST_OFF;
            default:
               state <= ST_OFF;
         endcase
      end
   end

   // Stage enables, all forced off under undervoltage lockout.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || UNDERVOLTAGE_FAULT_I)
      begin
         CARD_SUPPLY_ON_O <= 1'b0;
         lines_on <= 1'b0;
         clk_run <= 1'b0;
         rst_follow <= 1'b0;
      end
      else
      begin
         CARD_SUPPLY_ON_O <= !(state == ST_OFF || state == ST_D_PWR);
         lines_on <= (state == ST_LINES || state == ST_CLK || state == ST_ACTIVE ||
            state == ST_D_RST || state == ST_D_CLK);
         clk_run <= (state == ST_CLK || state == ST_ACTIVE || state == ST_D_RST);
         rst_follow <= (state == ST_ACTIVE);
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         CARD_SUPPLY_HIGH_O <= 1'b0;
      else
         CARD_SUPPLY_HIGH_O <= LINK.supply_class_select;
   end

   // The divider counts host clock rising edges, so it stops cleanly low.
   logic hclk_prev;
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         hclk_prev <= 1'b0;
         div_cnt <= '0;
      end
      else
      begin
         hclk_prev <= LINK.host_clock_in;
         if (!clk_run)
            div_cnt <= '0;
         else if (LINK.host_clock_in && !hclk_prev)
            div_cnt <= div_cnt + 3'h1;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || !clk_run || UNDERVOLTAGE_FAULT_I)
         CARD_CLOCK_OUT_O <= 1'b0;
      else
      begin
         case (div_sel)
            DIV_BY_1: CARD_CLOCK_OUT_O <= LINK.host_clock_in;
            DIV_BY_2: CARD_CLOCK_OUT_O <= div_cnt[0];
            DIV_BY_4: CARD_CLOCK_OUT_O <= div_cnt[1];
            default: CARD_CLOCK_OUT_O <= div_cnt[2];
         endcase
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || !rst_follow || UNDERVOLTAGE_FAULT_I)
         CARD_RESET_OUT_O <= 1'b0;
      else
         CARD_RESET_OUT_O <= LINK.host_reset_in;
   end

   // Open-drain both ways: a low seen on one side is driven low on the other.
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         CARD_LINE_O <= '0;
         CARD_LINE_OE_N_O <= 3'h0;
         LINK.host_line_from_dev <= '0;
         LINK.host_line_oe_n_dev <= 3'h7;
      end
      else
      begin
         CARD_LINE_O <= '0;
         LINK.host_line_from_dev <= '0;
         if (!lines_on || UNDERVOLTAGE_FAULT_I)
         begin
            CARD_LINE_OE_N_O <= 3'h0;
            LINK.host_line_oe_n_dev <= 3'h7;
         end
         else
         begin
            // Released lines float high via the card pull-up.
            CARD_LINE_OE_N_O <= ~(~LINK.host_line_oe_n_host & ~LINK.host_line_from_host);
            LINK.host_line_oe_n_dev <= ~(~CARD_LINE_I & LINK.host_line_oe_n_host);
         end
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         LINK.irq_n <= 1'b1;
      else
         LINK.irq_n <= ~(present | OVERCURRENT_FAULT_I);
   end
endmodule
